// [hw/dup_pkg.sv]
// Purpose: Shared constants and types for the dual UART pin and host front end.
// Assumes: One 50 MHz clock; channel index 0 is channel A, 1 is channel B.
// Notes: Register offsets and bit positions are local to this block.
package dup_pkg;
  // Register select offsets for the bits this block keeps.
  localparam logic [2:0] ADR_IER = 3'h1;
  localparam logic [2:0] ADR_AFR = 3'h2;
  localparam logic [2:0] ADR_EFR = 3'h3;
  localparam logic [2:0] ADR_MCR = 3'h4;
  localparam logic [2:0] ADR_GPI = 3'h6;
  // Bit positions inside the registers.
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OP2 = 3;
  localparam int MCR_IRDA = 6;
  localparam int IER_ARTS = 6;
  localparam int IER_ACTS = 7;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;
  localparam int AFR_BCAST = 0;
  localparam int AFR_MF_LO = 1;
  localparam int AFR_IRINV = 4;
  // Reset and filler values.
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam logic CH_A = 1'b0;
  localparam logic CH_B = 1'b1;
  localparam logic [1:0] TGT_BOTH = 2'h3;
  localparam logic [1:0] TGT_ONE = 2'h1;
  // Multi-function output selection.
  typedef enum logic [1:0] {
    MF_OP2 = 2'b00,
    MF_BAUD = 2'b01,
    MF_RXRDY = 2'b10,
    MF_OP2_ALT = 2'b11
  } dup_mf_e;
  // Host access sequencer states.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_READ = 2'b01,
    BUS_WRITE = 2'b10
  } dup_bus_e;
  // One register write toward a channel.
  typedef struct packed {
    logic en;
    logic [2:0] addr;
    logic [7:0] data;
  } dup_wr_s;
  // Status from the UART core of one channel.
  typedef struct packed {
    logic irq;
    logic tx_space;
    logic rx_avail;
    logic baud_clk;
    logic tx_bit;
    logic rts_ok;
  } dup_core_in_s;
  // Line signals handed to the UART core of one channel.
  typedef struct packed {
    logic rx_bit;
    logic cts_ok;
    logic irda;
  } dup_core_out_s;
endpackage : dup_pkg

// [hw/dup_chan.sv]
// Purpose: Registers and pin logic of one channel.
// Assumes: Writes arrive as one-cycle pulses from the host front end.
// Notes: All pin outputs and core outputs are registered.
`timescale 1ns/1ps
module dup_chan (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Register access.
  input wire dup_pkg::dup_wr_s wr,
  input wire logic [2:0] rd_addr,
  output logic [7:0] rd_data,
  output logic bcast,
  // Raw channel pins.
  input wire logic cts_n,
  input wire logic rx_in,
  input wire logic dsr_n,
  input wire logic cd_n,
  input wire logic ri_n,
  output logic tx_out,
  output logic rts_n,
  output logic dtr_n,
  output logic mf_n,
  output logic irq,
  output logic txrdy_n,
  // UART core side.
  input wire dup_pkg::dup_core_in_s core_in,
  output dup_pkg::dup_core_out_s core_out
);
  logic [7:0] mcr_r, mcr_nxt, ier_r, ier_nxt, efr_r, efr_nxt, afr_r, afr_nxt;
  logic [4:0] s1_r, s2_r;
  logic tx_nxt, rts_nxt, dtr_nxt, mf_nxt, irq_nxt, txrdy_nxt;
  dup_pkg::dup_core_out_s core_nxt;
  dup_pkg::dup_mf_e mf_sel;
  logic rx_s, cts_s, rx_pulse;

  // Two flops on every pin input; only the second stage is read.
  always_ff @(posedge clock)
  begin
    s1_r <= {cts_n, rx_in, dsr_n, cd_n, ri_n};
    s2_r <= s1_r;
  end
  assign cts_s = s2_r[4];
  assign rx_s = s2_r[3];
  assign mf_sel = dup_pkg::dup_mf_e'(afr_r[dup_pkg::AFR_MF_LO +: 2]);
  assign bcast = afr_r[dup_pkg::AFR_BCAST];

  // Register writes; a write to an unused offset is dropped.
  always_comb
  begin
    mcr_nxt = mcr_r;
    ier_nxt = ier_r;
    efr_nxt = efr_r;
    afr_nxt = afr_r;
    if (wr.en)
    begin
      case (wr.addr)
        dup_pkg::ADR_MCR: mcr_nxt = wr.data;
        dup_pkg::ADR_IER: ier_nxt = wr.data;
        dup_pkg::ADR_EFR: efr_nxt = wr.data;
        dup_pkg::ADR_AFR: afr_nxt = wr.data;
        default: mcr_nxt = mcr_r;
      endcase
    end
  end

  // Read mux; ready, carrier and ring inputs show up only here and steer nothing else.
  always_comb
  begin
    case (rd_addr)
      dup_pkg::ADR_MCR: rd_data = mcr_r;
      dup_pkg::ADR_IER: rd_data = ier_r;
      dup_pkg::ADR_EFR: rd_data = efr_r;
      dup_pkg::ADR_AFR: rd_data = afr_r;
      dup_pkg::ADR_GPI: rd_data = {4'h0, ~s2_r[4], ~s2_r[2:0]};
      default: rd_data = dup_pkg::RD_NONE;
    endcase
  end

  // Pin and core outputs.
  always_comb
  begin
    irq_nxt = core_in.irq;
    txrdy_nxt = ~core_in.tx_space;
    dtr_nxt = ~mcr_r[dup_pkg::MCR_DTR];
    // Auto RTS only gates a request that software already made.
    rts_nxt = ~mcr_r[dup_pkg::MCR_RTS];
    if (efr_r[dup_pkg::EFR_ARTS] && ier_r[dup_pkg::IER_ARTS])
      rts_nxt = ~(mcr_r[dup_pkg::MCR_RTS] & core_in.rts_ok);
    // IrDA sends a pulse per zero bit, so the line idles low.
    if (mcr_r[dup_pkg::MCR_IRDA])
      tx_nxt = ~core_in.tx_bit & core_in.baud_clk;
    else
      tx_nxt = core_in.tx_bit;
    rx_pulse = rx_s ^ afr_r[dup_pkg::AFR_IRINV];
    core_nxt.irda = mcr_r[dup_pkg::MCR_IRDA];
    core_nxt.rx_bit = mcr_r[dup_pkg::MCR_IRDA] ? ~rx_pulse : rx_s;
    core_nxt.cts_ok = 1'b1;
    if (efr_r[dup_pkg::EFR_ACTS] && ier_r[dup_pkg::IER_ACTS])
      core_nxt.cts_ok = ~cts_s;
    case (mf_sel)
      dup_pkg::MF_BAUD: mf_nxt = ~core_in.baud_clk;
      dup_pkg::MF_RXRDY: mf_nxt = ~core_in.rx_avail;
      default: mf_nxt = ~mcr_r[dup_pkg::MCR_OP2];
    endcase
  end

  // State registers; reset leaves the transmit line marking.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mcr_r <= dup_pkg::REG_RST;
      ier_r <= dup_pkg::REG_RST;
      efr_r <= dup_pkg::REG_RST;
      afr_r <= dup_pkg::REG_RST;
      tx_out <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      mf_n <= 1'b1;
      irq <= 1'b0;
      txrdy_n <= 1'b1;
      core_out <= '{rx_bit: 1'b1, cts_ok: 1'b1, irda: 1'b0};
    end
    else
    begin
      mcr_r <= mcr_nxt;
      ier_r <= ier_nxt;
      efr_r <= efr_nxt;
      afr_r <= afr_nxt;
      tx_out <= tx_nxt;
      rts_n <= rts_nxt;
      dtr_n <= dtr_nxt;
      mf_n <= mf_nxt;
      irq <= irq_nxt;
      txrdy_n <= txrdy_nxt;
      core_out <= core_nxt;
    end
  end

  irq_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 irq == $past(core_in.irq)) else $error("irq does not follow core");
  txrdy_a: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 txrdy_n == !$past(core_in.tx_space)) else $error("txrdy mismatch");
  tx_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    !mcr_r[dup_pkg::MCR_IRDA] && core_in.tx_bit |=> tx_out)
    else $error("tx not high when idle");
  irda_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    mcr_r[dup_pkg::MCR_IRDA] && core_in.tx_bit |=> !tx_out)
    else $error("irda tx not low when idle");
  op2_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mf_sel == dup_pkg::MF_OP2) && mcr_r[dup_pkg::MCR_OP2] |=> !mf_n)
    else $error("op2 not low");
  baud_out_a: assert property (@(posedge clock) disable iff (sys_rst)
    mf_sel == dup_pkg::MF_BAUD |=> mf_n == !$past(core_in.baud_clk))
    else $error("baud not out");
  rxrdy_out_a: assert property (@(posedge clock) disable iff (sys_rst)
    mf_sel == dup_pkg::MF_RXRDY |=> mf_n == !$past(core_in.rx_avail))
    else $error("rxrdy bad");
  cts_free_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(efr_r[dup_pkg::EFR_ACTS] && ier_r[dup_pkg::IER_ACTS]) |=> core_out.cts_ok)
    else $error("cts gated while off");
  irda_cov: cover property (@(posedge clock) disable iff (sys_rst)
    mcr_r[dup_pkg::MCR_IRDA] ##1 tx_out);
  gate_cov: cover property (@(posedge clock) disable iff (sys_rst) !core_out.cts_ok);
endmodule : dup_chan

// [hw/dup_top.sv]
// Purpose: Host strobe front end and pins of a two channel UART.
// Assumes: Address and data are stable from strobe fall until two clocks after its rise.
// Notes: Strobes are oversampled, so each strobe level must last at least three clocks.
// Behaviour
// - With chip select low, channel pick high addresses A, low addresses B.
// - Broadcast bit set: one host write reaches both channels, ignoring channel pick.
// - Each interrupt output is high while its channel requests service.
// - Active-low transmit-ready output shows transmit buffer space of its channel.
// - Normal mode uses plain serial; transmit line high in reset and idle.
// - Infrared mode uses pulse encoder and decoder; transmit line idles low.
// - Receive idles high normally; infrared receive may be inverted by software.
// - Request-to-send is software driven; auto mode only gates that request.
// - Clear-to-send is a plain input or gates transmit when auto mode is on.
// - Ready, carrier and ring inputs are readable only and affect nothing.
// - Terminal-ready output is active low and software controlled.
// - Multi-function output carries one of three functions chosen by two bits.
// - User output two drives low while its control bit is one; resets zero.
// - Baud clock selection presents the channel baud clock on the output.
// - Receive-ready selection gives an active-low data available flag.
// - Three address bits pick one register of the selected channel.
// - Read strobe fall drives the addressed byte until the strobe rises.
// - Write strobe rise stores the data byte into the addressed register.
`timescale 1ns/1ps
module dup_top (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Host bus.
  input wire logic CS_N,
  input wire logic CHANNEL_PICK,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  // Channel A pins.
  output logic IRQ_OUT_CHAN_A,
  output logic TX_SPACE_FLAG_A_N,
  output logic SERIAL_OUT_A,
  input wire logic SERIAL_IN_A,
  output logic REQ_TO_SEND_A_N,
  input wire logic CLEAR_TO_SEND_A_N,
  output logic TERM_READY_A_N,
  input wire logic SET_READY_A_N,
  input wire logic CARRIER_SENSE_A_N,
  input wire logic RING_SENSE_A_N,
  output logic MULTI_FUNC_OUT_A_N,
  // Channel B pins.
  output logic IRQ_OUT_CHAN_B,
  output logic TX_SPACE_FLAG_B_N,
  output logic SERIAL_OUT_B,
  input wire logic SERIAL_IN_B,
  output logic REQ_TO_SEND_B_N,
  input wire logic CLEAR_TO_SEND_B_N,
  output logic TERM_READY_B_N,
  input wire logic SET_READY_B_N,
  input wire logic CARRIER_SENSE_B_N,
  input wire logic RING_SENSE_B_N,
  output logic MULTI_FUNC_OUT_B_N,
  // UART core side.
  input wire dup_pkg::dup_core_in_s CORE_IN_A,
  input wire dup_pkg::dup_core_in_s CORE_IN_B,
  output dup_pkg::dup_core_out_s CORE_OUT_A,
  output dup_pkg::dup_core_out_s CORE_OUT_B
);
  dup_pkg::dup_bus_e st_r, st_nxt;
  dup_pkg::dup_wr_s wr_r, wr_nxt;
  logic [1:0] tgt_r, tgt_nxt;
  logic ch_r, ch_nxt, doe_nxt, chan, cs, bcast_any;
  logic [7:0] dout_nxt;
  logic [3:0] s1_r, s2_r, s3_r;
  logic [10:0] ad1_r, ad2_r;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  logic rd_fall, rd_rise, wr_fall, wr_rise;
  logic [7:0] rd_w [2];
  logic [1:0] bc_w, cts_w, rx_w, dsr_w, cd_w, ri_w;
  logic [1:0] tx_w, rts_w, dtr_w, mf_w, irq_w, txr_w;
  dup_pkg::dup_core_in_s cin_w [2];
  dup_pkg::dup_core_out_s cout_w [2];

  // Host control pins pass two flops; the third stage is only for edges.
  always_ff @(posedge CLOCK)
  begin
    s1_r <= {CS_N, CHANNEL_PICK, READ_STROBE_N, WRITE_STROBE_N};
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  // Address and data pins pass two flops too; the host holds them past the strobe.
  always_ff @(posedge CLOCK)
  begin
    ad1_r <= {ADDR, DATA_IN};
    ad2_r <= ad1_r;
  end
  assign addr_s = ad2_r[10:8];
  assign data_s = ad2_r[7:0];
  assign cs = ~s2_r[3];
  assign chan = s2_r[2] ? dup_pkg::CH_A : dup_pkg::CH_B;
  assign rd_fall = s3_r[1] & ~s2_r[1];
  assign rd_rise = ~s3_r[1] & s2_r[1];
  assign wr_fall = s3_r[0] & ~s2_r[0];
  assign wr_rise = ~s3_r[0] & s2_r[0];
  assign bcast_any = |bc_w;

  // Access sequencer: channel is caught at strobe fall, write lands at rise.
  always_comb
  begin
    st_nxt = st_r;
    ch_nxt = ch_r;
    dout_nxt = DATA_OUT;
    doe_nxt = DATA_OE;
    wr_nxt = '0;
    tgt_nxt = tgt_r;
    case (st_r)
      dup_pkg::BUS_IDLE:
      begin
        if (cs && rd_fall)
        begin
          st_nxt = dup_pkg::BUS_READ;
          ch_nxt = chan;
          dout_nxt = rd_w[chan];
          doe_nxt = 1'b1;
        end
        else if (cs && wr_fall)
        begin
          st_nxt = dup_pkg::BUS_WRITE;
          ch_nxt = chan;
        end
      end
      dup_pkg::BUS_READ:
      begin
        if (rd_rise)
        begin
          st_nxt = dup_pkg::BUS_IDLE;
          doe_nxt = 1'b0;
        end
      end
      dup_pkg::BUS_WRITE:
      begin
        if (wr_rise)
        begin
          st_nxt = dup_pkg::BUS_IDLE;
          wr_nxt = '{en: 1'b1, addr: addr_s, data: data_s};
          // Broadcast ignores the pick so setup code can program both at once.
          tgt_nxt = bcast_any ? dup_pkg::TGT_BOTH : (dup_pkg::TGT_ONE << ch_r);
        end
      end
      default: st_nxt = dup_pkg::BUS_IDLE;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      st_r <= dup_pkg::BUS_IDLE;
      ch_r <= dup_pkg::CH_A;
      DATA_OUT <= dup_pkg::RD_NONE;
      DATA_OE <= 1'b0;
      wr_r <= '0;
      tgt_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      ch_r <= ch_nxt;
      DATA_OUT <= dout_nxt;
      DATA_OE <= doe_nxt;
      wr_r <= wr_nxt;
      tgt_r <= tgt_nxt;
    end
  end

  // Gather per-channel pins into arrays, index 0 for A.
  assign cts_w = {CLEAR_TO_SEND_B_N, CLEAR_TO_SEND_A_N};
  assign rx_w = {SERIAL_IN_B, SERIAL_IN_A};
  assign dsr_w = {SET_READY_B_N, SET_READY_A_N};
  assign cd_w = {CARRIER_SENSE_B_N, CARRIER_SENSE_A_N};
  assign ri_w = {RING_SENSE_B_N, RING_SENSE_A_N};
  assign cin_w[0] = CORE_IN_A;
  assign cin_w[1] = CORE_IN_B;

  // One register and pin slice per channel.
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    dup_pkg::dup_wr_s wr_ch;
    // Each channel sees the shared write only when it is one of the targets.
    assign wr_ch = '{en: wr_r.en & tgt_r[i], addr: wr_r.addr, data: wr_r.data};
    dup_chan u_chan (
      .clock(CLOCK),
      .sys_rst(SYS_RST),
      .wr(wr_ch),
      .rd_addr(addr_s),
      .rd_data(rd_w[i]),
      .bcast(bc_w[i]),
      .cts_n(cts_w[i]),
      .rx_in(rx_w[i]),
      .dsr_n(dsr_w[i]),
      .cd_n(cd_w[i]),
      .ri_n(ri_w[i]),
      .tx_out(tx_w[i]),
      .rts_n(rts_w[i]),
      .dtr_n(dtr_w[i]),
      .mf_n(mf_w[i]),
      .irq(irq_w[i]),
      .txrdy_n(txr_w[i]),
      .core_in(cin_w[i]),
      .core_out(cout_w[i])
    );
  end

  // Outputs come straight from the channel flops.
  assign {IRQ_OUT_CHAN_B, IRQ_OUT_CHAN_A} = irq_w;
  assign {TX_SPACE_FLAG_B_N, TX_SPACE_FLAG_A_N} = txr_w;
  assign {SERIAL_OUT_B, SERIAL_OUT_A} = tx_w;
  assign {REQ_TO_SEND_B_N, REQ_TO_SEND_A_N} = rts_w;
  assign {TERM_READY_B_N, TERM_READY_A_N} = dtr_w;
  assign {MULTI_FUNC_OUT_B_N, MULTI_FUNC_OUT_A_N} = mf_w;
  assign CORE_OUT_A = cout_w[0];
  assign CORE_OUT_B = cout_w[1];

  bcast_both_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    st_r == dup_pkg::BUS_WRITE && wr_rise && bcast_any |=> wr_r.en && tgt_r == dup_pkg::TGT_BOTH)
    else $error("broadcast write missed a channel");
  pick_route_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    st_r == dup_pkg::BUS_IDLE && cs && (rd_fall || wr_fall) |=> ch_r == !$past(s2_r[2]))
    else $error("channel pick misrouted");
  read_drive_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    st_r == dup_pkg::BUS_READ && !rd_rise |=> DATA_OE) else $error("read data dropped early");
  write_once_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    wr_r.en |=> !wr_r.en) else $error("write pulse longer than one cycle");
  bcast_cov: cover property (@(posedge CLOCK) disable iff (SYS_RST)
    wr_r.en && tgt_r == dup_pkg::TGT_BOTH);
  read_cov: cover property (@(posedge CLOCK) disable iff (SYS_RST) DATA_OE ##1 !DATA_OE);
endmodule : dup_top

// [sim/dup_host_model.sv]
// Purpose: Host processor model that runs strobe cycles on the parallel bus.
// Assumes: Each strobe level lasts at least six clocks, above the three the front end needs.
// Notes: Lines the host has let go show the inverse of their last value.
`timescale 1ns/1ps
module dup_host_model (
  // Clock.
  input wire logic clock,
  // Lines toward the device.
  output logic cs_n,
  output logic pick,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] addr,
  output logic [7:0] wr_data,
  // Lines from the device.
  input wire logic [7:0] rd_data,
  input wire logic rd_oe
);
  localparam int HOLD = 6;
  // Idle bus, so no access is seen at start-up.
  initial
  begin
    cs_n = 1'b1;
    pick = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
    wr_data = 8'hA5;
  end
  // One access; select and address stand until well after the strobe rises.
  task automatic access(input logic is_wr, input logic ch, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(negedge clock);
    cs_n = 1'b0;
    pick = ch;
    addr = a;
    wr_data = is_wr ? d : ~wr_data;
    if (is_wr)
    begin
      wr_n = 1'b0;
    end
    else
    begin
      rd_n = 1'b0;
    end
    repeat (HOLD) @(negedge clock);
    q = rd_data;
    oe = rd_oe;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (HOLD) @(negedge clock);
    cs_n = 1'b1;
    pick = ~pick;
    addr = ~a;
    wr_data = ~wr_data;
  endtask : access
endmodule : dup_host_model

// [sim/testbench.sv]
// Purpose: Self-checking bench of the dual channel pin and host front end.
// Assumes: Core side inputs are driven here in place of the UART cores.
// Notes: Waits are the fixed latencies of the front end, not handshakes.
`timescale 1ns/1ps
module testbench;
  logic clock, sys_rst, cs_n, pick, rd_n, wr_n, doe;
  logic [2:0] addr;
  logic [7:0] din, dout, q;
  logic irq_a, txf_a_n, so_a, si_a, rts_a_n, cts_a_n, dtr_a_n, dsr_a_n, cd_a_n, ri_a_n, mf_a_n;
  logic irq_b, txf_b_n, so_b, si_b, rts_b_n, cts_b_n, dtr_b_n, dsr_b_n, cd_b_n, ri_b_n, mf_b_n;
  dup_pkg::dup_core_in_s cin_a, cin_b;
  dup_pkg::dup_core_out_s cout_a, cout_b;
  int errors, n_compared, cycles;
  dup_top dup_top_inst (.CLOCK(clock), .SYS_RST(sys_rst), .CS_N(cs_n), .CHANNEL_PICK(pick),
    .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .ADDR(addr), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE(doe), .IRQ_OUT_CHAN_A(irq_a), .TX_SPACE_FLAG_A_N(txf_a_n),
    .SERIAL_OUT_A(so_a), .SERIAL_IN_A(si_a), .REQ_TO_SEND_A_N(rts_a_n),
    .CLEAR_TO_SEND_A_N(cts_a_n), .TERM_READY_A_N(dtr_a_n), .SET_READY_A_N(dsr_a_n),
    .CARRIER_SENSE_A_N(cd_a_n), .RING_SENSE_A_N(ri_a_n), .MULTI_FUNC_OUT_A_N(mf_a_n),
    .IRQ_OUT_CHAN_B(irq_b), .TX_SPACE_FLAG_B_N(txf_b_n), .SERIAL_OUT_B(so_b),
    .SERIAL_IN_B(si_b), .REQ_TO_SEND_B_N(rts_b_n), .CLEAR_TO_SEND_B_N(cts_b_n),
    .TERM_READY_B_N(dtr_b_n), .SET_READY_B_N(dsr_b_n), .CARRIER_SENSE_B_N(cd_b_n),
    .RING_SENSE_B_N(ri_b_n), .MULTI_FUNC_OUT_B_N(mf_b_n), .CORE_IN_A(cin_a),
    .CORE_IN_B(cin_b), .CORE_OUT_A(cout_a), .CORE_OUT_B(cout_b));
  dup_host_model dup_host_model_inst (.clock(clock), .cs_n(cs_n), .pick(pick), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .wr_data(din), .rd_data(dout), .rd_oe(doe));
  // Clock, and a cycle ceiling that cuts a hang short.
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("[FAIL] %0t: run did not finish in time", $time);
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    logic oe;
    dup_host_model_inst.access(1'b1, ch, a, d, q, oe);
  endtask : wr
  task automatic rd_chk(input logic ch, input logic [2:0] a, input logic [7:0] exp);
    logic oe;
    dup_host_model_inst.access(1'b0, ch, a, 8'h00, q, oe);
    check(q, exp);
    check(8'(oe), 8'h01);
  endtask : rd_chk
  // Pin inputs pass two sync stages and one output register.
  task automatic settle();
    repeat (4) @(negedge clock);
  endtask : settle
  // Channel pick routes writes and reads to one channel only.
  task automatic t_route();
    wr(1'b1, dup_pkg::ADR_MCR, 8'h0B);
    check(8'({dtr_a_n, rts_a_n, mf_a_n, dtr_b_n, rts_b_n, mf_b_n}), 8'h07);
    rd_chk(1'b1, dup_pkg::ADR_MCR, 8'h0B);
    rd_chk(1'b0, dup_pkg::ADR_MCR, 8'h00);
    rd_chk(1'b1, 3'h7, 8'h00);
  endtask : t_route
  // Broadcast writes land in both channels whatever the pick says.
  task automatic t_bcast();
    wr(1'b1, dup_pkg::ADR_AFR, 8'h01);
    wr(1'b0, dup_pkg::ADR_MCR, 8'h01);
    check(8'({dtr_a_n, dtr_b_n, rts_a_n, mf_a_n}), 8'h03);
    wr(1'b0, dup_pkg::ADR_AFR, 8'h00);
    wr(1'b0, dup_pkg::ADR_MCR, 8'h0A);
    check(8'({dtr_a_n, dtr_b_n, rts_b_n}), 8'h02);
    wr(1'b1, dup_pkg::ADR_MCR, 8'h08);
  endtask : t_bcast
  // Every select code against both levels of baud clock and receive flag.
  task automatic t_mf();
    logic [1:0] sel;
    logic b;
    logic exp;
    for (int s = 0; s < 4; s++)
    begin
      sel = 2'(s);
      wr(1'b1, dup_pkg::ADR_AFR, {5'h00, sel, 1'b0});
      for (int k = 0; k < 2; k++)
      begin
        b = 1'(k);
        cin_a.baud_clk = b;
        cin_a.rx_avail = ~b;
        settle();
        exp = (sel == 2'b01) ? ~b : (sel == 2'b10) ? b : 1'b0;
        check(8'(mf_a_n), 8'(exp));
      end
    end
    wr(1'b1, dup_pkg::ADR_AFR, 8'h00);
  endtask : t_mf
  // Interrupt and transmit flag follow the core of their own channel.
  task automatic t_core();
    cin_b.irq = 1'b1;
    cin_b.tx_space = 1'b1;
    si_b = 1'b0;
    settle();
    check(8'({irq_b, txf_b_n, irq_a, txf_a_n}), 8'h09);
    check(8'(cout_b), 8'h02);
    cin_b.irq = 1'b0;
    settle();
    check(8'(irq_b), 8'h00);
  endtask : t_core
  // Plain and infrared line paths, with the receive inversion.
  task automatic t_irda();
    cin_a.tx_bit = 1'b0;
    settle();
    check(8'({so_a, cout_a.rx_bit, cout_a.irda}), 8'h02);
    wr(1'b1, dup_pkg::ADR_MCR, 8'h48);
    cin_a.tx_bit = 1'b1;
    si_a = 1'b0;
    settle();
    check(8'({so_a, cout_a.rx_bit, cout_a.irda}), 8'h03);
    cin_a.tx_bit = 1'b0;
    cin_a.baud_clk = 1'b1;
    si_a = 1'b1;
    settle();
    check(8'({so_a, cout_a.rx_bit}), 8'h02);
    wr(1'b1, dup_pkg::ADR_AFR, 8'h10);
    check(8'(cout_a.rx_bit), 8'h01);
  endtask : t_irda
  // Automatic flow control gates and the general purpose status byte.
  task automatic t_flow();
    wr(1'b1, dup_pkg::ADR_MCR, 8'h02);
    check(8'(rts_a_n), 8'h00);
    wr(1'b1, dup_pkg::ADR_IER, 8'hC0);
    wr(1'b1, dup_pkg::ADR_EFR, 8'hC0);
    check(8'({rts_a_n, cout_a.cts_ok}), 8'h02);
    cin_a.rts_ok = 1'b1;
    cin_a.tx_bit = 1'b1;
    cts_a_n = 1'b0;
    dsr_a_n = 1'b0;
    settle();
    check(8'({rts_a_n, cout_a.cts_ok}), 8'h01);
    rd_chk(1'b1, dup_pkg::ADR_GPI, 8'h0C);
    check(8'(so_a), 8'h01);
  endtask : t_flow
  task automatic give_verdict();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Main sequence: reset, then one task per scenario.
  initial
  begin
    errors = 0;
    n_compared = 0;
    cycles = 0;
    sys_rst = 1'b1;
    {si_a, si_b, cts_a_n, cts_b_n} = 4'hF;
    {dsr_a_n, cd_a_n, ri_a_n, dsr_b_n, cd_b_n, ri_b_n} = 6'h3F;
    cin_a = '0;
    cin_b = '0;
    repeat (16) @(negedge clock);
    check(8'({so_a, so_b, rts_a_n, dtr_a_n, mf_a_n, txf_a_n, irq_a, doe}), 8'hFC);
    sys_rst = 1'b0;
    repeat (3) @(negedge clock);
    t_route();
    t_bcast();
    t_mf();
    t_core();
    t_irda();
    t_flow();
    give_verdict();
  end
endmodule : testbench
